// File: verilog/cstw_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the clock system.
// Assumes: One aligned 32-bit word per register on AHB-Lite.
// Notes: Definitions only.
`ifndef CSTW_MAP_SVH
`define CSTW_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CSTW_OFF_CTRL 8'h00
`define CSTW_OFF_FASTTC 8'h04
`define CSTW_OFF_CTCMATCH 8'h08
`define CSTW_OFF_STATUS 8'h0C
`define CSTW_OFF_SRCSEL 8'h10
`define CSTW_OFF_PLLDIV 8'h14
`define CSTW_OFF_DIV0 8'h40
`define CSTW_NUM_DIV 14
`define CSTW_DIV_BUS 12
`define CSTW_DIV_CPU 13

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CSTW_CTRL_CLR_BIT 0
`define CSTW_STAT_FAST_LSB 16
`define CSTW_STAT_LOCK_BIT 24
`define CSTW_SRC_DBL_LSB 4
`define CSTW_SRC_PLL_LSB 8
`define CSTW_PLL_FB_LSB 8
`define CSTW_DIVREG_SRC_LSB 16

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define CSTW_FASTTC_RST 5'h1F
`define CSTW_CTCMATCH_RST 13'h1FFF
`define CSTW_DIVISOR_RST 16'h0002
`define CSTW_LOW_DIV 16'h0003
`define CSTW_CLK_PERIOD_NS 10
`define CSTW_PLL_LOCK_NS 250000
`define CSTW_PLL_LOCK_CYC (`CSTW_PLL_LOCK_NS / `CSTW_CLK_PERIOD_NS)
`define CSTW_WATCH_EDGES 32768

`endif

// File: verilog/cstw_pkg.sv
// Purpose: Types shared by the clock system files.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Numbers live in cstw_map.svh.
package cstw_pkg;

  // Reference choice for the doubler and the PLL.
  typedef enum logic [1:0] {
    REF_MAIN = 2'b00,
    REF_XTAL = 2'b01,
    REF_FABRIC = 2'b10
  } cstw_ref_e;

  // Main oscillator frequency choice: 3, 6, 12 or 24 MHz.
  typedef enum logic [1:0] {
    MAIN_3M = 2'b00,
    MAIN_6M = 2'b01,
    MAIN_12M = 2'b10,
    MAIN_24M = 2'b11
  } cstw_main_e;

  // PLL lock tracker states.
  typedef enum logic [1:0] {
    LK_OFF = 2'b00,
    LK_WAIT = 2'b01,
    LK_DONE = 2'b10
  } cstw_lock_e;

  // Control word, bits 6:1 of the control register.
  typedef struct packed {
    logic usbLock;
    logic watchPwr;
    logic pllEn;
    logic ctcWakeEn;
    logic ctcIrqEn;
    logic fastIrqEn;
  } cstw_ctrl_s;

  // One divider's setup.
  typedef struct packed {
    logic [2:0] src;
    logic [15:0] divisor;
  } cstw_div_s;

endpackage : cstw_pkg

// File: verilog/cstw_clkdiv.sv
// Purpose: Source-selectable divider with near 50% duty output.
// Assumes: Source levels are synchronous to ref_clk and much slower than it.
// Notes: A new setup is taken only at the end of a low phase.
`include "cstw_map.svh"

module cstw_clkdiv
  import cstw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] srcLvl,
  input wire cstw_div_s setup,
  output logic clkOut
);

  cstw_div_s act_q; // Setup in force.
  logic [7:0] prev_q; // Previous source levels.
  logic [15:0] cnt_q; // Source edges in this period.
  logic [15:0] div; // Divisor, at least two.
  logic edgeHit; // Rising edge of the chosen source.

  assign div = (act_q.divisor < 16'h0002) ? 16'h0002 : act_q.divisor;
  assign edgeHit = srcLvl[act_q.src] & ~prev_q[act_q.src];

  // Remember every source so a switch sees no false edge.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= srcLvl;
    end
  end

  // Count edges; output is high for the first half of the period.
  // The setup is swapped only when the output is low and the period
  // closes, so no runt pulse can appear on a change.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      clkOut <= 1'b0;
      act_q <= '{src: 3'h0, divisor: `CSTW_DIVISOR_RST};
    end else if (edgeHit) begin
      if (cnt_q >= div - 16'h0001) begin
        cnt_q <= 16'h0000;
        clkOut <= 1'b1;
        act_q <= setup;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        clkOut <= (cnt_q + 16'h0001) < (div >> 1);
      end
    end
  end

  // Output moves only on a source edge.
  glitch_free_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(clkOut) |-> $past(edgeHit)) else $error("divider output moved without source edge");

endmodule : cstw_clkdiv

// File: verilog/cstw_clock_sys.sv
// Purpose: Clock source control, tick counters and dividers behind an AHB-Lite slave.
// Assumes: Oscillator levels arrive synchronous to ref_clk; analog parts sit outside.
// Notes: Zero wait state slave, every answer OKAY.
//
// How it works
// - 13-bit central counter steps on 1 kHz edges
// - Central counter halts in hibernate or debug halt
// - Firmware clears central counter to zero
// - Central counter match raises interrupt, and wakeup in low power
// - 5-bit fast counter on 100 kHz, programmable end
// - Fast counter restarts itself at terminal count
// - Fast interrupt only when enabled
// - 1, 33 and 100 kHz clocks offered
// - 33 kHz is 100 kHz divided by three
// - Main oscillator 3/6/12/24 MHz, own trim each
// - Doubler input from main, crystal or fabric
// - PLL reference from main, crystal or fabric
// - PLL input and feedback dividers, 4096 ratios
// - PLL lock bit after lock time; gate output
// - Lock indication driven out to fabric
// - Divided outputs have 50% duty for even divisors
// - Eight digital, four analog, bus and CPU dividers
// - Watch crystal gives one-second interrupt
// - Watch crystal power mode selectable
// - USB lock mode for main oscillator
`include "cstw_map.svh"

module cstw_clock_sys
  import cstw_pkg::*;
#(
  parameter int LOCK_CYC = `CSTW_PLL_LOCK_CYC,
  parameter int WATCH_EDGES = `CSTW_WATCH_EDGES,
  parameter logic [31:0] TRIM_TABLE = 32'h80808080
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mainOscClk,
  input wire logic fastXtalClk,
  input wire logic fabricClk,
  input wire logic pllClk,
  input wire logic doublerClk,
  input wire logic lowSpeed1k,
  input wire logic lowSpeed100k,
  input wire logic watchXtalClk,
  input wire logic hibernate,
  input wire logic debugHalt,
  input wire logic lowPower,
  output logic slowTickClk,
  output logic fastLowClk,
  output logic dividedLowClk,
  output logic [13:0] divClk,
  output logic ctcIrq,
  output logic ctcWake,
  output logic fastIrq,
  output logic rtcSecIrq,
  output logic pllLock,
  output logic pllLockFabric,
  output logic pllEnable,
  output logic [5:0] pllInDiv,
  output logic [5:0] pllFbDiv,
  output cstw_ref_e pllSrc,
  output cstw_ref_e doublerSrc,
  output cstw_main_e mainFreq,
  output logic [7:0] mainTrim,
  output logic watchPwr,
  output logic usbLock
);

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic wrPend_q; // Write data phase follows.
  logic [7:0] wrAddr_q; // Offset of the pending write.
  logic take; // Address phase accepted.
  logic [7:0] off; // Offset in the page.
  cstw_ctrl_s ctrl_q; // Control bits.
  logic clrReq_q; // One-cycle central counter clear.
  logic [4:0] fastTc_q; // Fast counter terminal count.
  logic [12:0] ctcMatch_q; // Central counter match value.
  logic [1:0] freqSel_q; // Main oscillator frequency.
  logic [1:0] dblSel_q; // Doubler input.
  logic [1:0] pllSel_q; // PLL reference.
  logic [5:0] inDiv_q; // PLL input divider.
  logic [5:0] fbDiv_q; // PLL feedback divider.
  cstw_div_s divCfg_q [`CSTW_NUM_DIV]; // Divider setups.
  logic [12:0] ctc_q; // Central counter.
  logic [4:0] fast_q; // Fast counter.
  cstw_lock_e lk_q; // Lock tracker.

  assign take = hsel & htrans[1] & hready;
  assign off = haddr[7:0];

  // Index of a divider register, or 15 for none.
  function automatic logic [3:0] divIdx(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `CSTW_OFF_DIV0;
    if (a >= `CSTW_OFF_DIV0 && rel[1:0] == 2'b00 && rel[7:2] < `CSTW_NUM_DIV) begin
      divIdx = rel[5:2];
    end else begin
      divIdx = 4'hF;
    end
  endfunction : divIdx

  // Read value of an offset; holes read zero.
  function automatic logic [31:0] readVal(input logic [7:0] a);
    logic [3:0] i;
    readVal = 32'h0000_0000;
    i = divIdx(a);
    if (a == `CSTW_OFF_CTRL) begin
      readVal[6:1] = ctrl_q;
    end else if (a == `CSTW_OFF_FASTTC) begin
      readVal[4:0] = fastTc_q;
    end else if (a == `CSTW_OFF_CTCMATCH) begin
      readVal[12:0] = ctcMatch_q;
    end else if (a == `CSTW_OFF_STATUS) begin
      readVal[12:0] = ctc_q;
      readVal[`CSTW_STAT_FAST_LSB +: 5] = fast_q;
      readVal[`CSTW_STAT_LOCK_BIT] = pllLock;
    end else if (a == `CSTW_OFF_SRCSEL) begin
      readVal[1:0] = freqSel_q;
      readVal[`CSTW_SRC_DBL_LSB +: 2] = dblSel_q;
      readVal[`CSTW_SRC_PLL_LSB +: 2] = pllSel_q;
    end else if (a == `CSTW_OFF_PLLDIV) begin
      readVal[5:0] = inDiv_q;
      readVal[`CSTW_PLL_FB_LSB +: 6] = fbDiv_q;
    end else if (i != 4'hF) begin
      readVal[15:0] = divCfg_q[i].divisor;
      readVal[`CSTW_DIVREG_SRC_LSB +: 3] = divCfg_q[i].src;
    end
  endfunction : readVal

  // Never stall and always answer OKAY, so the data phase is one cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is prepared at the address phase so it stands in the data phase.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= readVal(off);
    end
  end

  // Latch the write address; data comes one cycle later.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= take & hwrite;
      wrAddr_q <= off;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Writes land in the data phase. The clear bit is a self-ending pulse.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      clrReq_q <= 1'b0;
      fastTc_q <= `CSTW_FASTTC_RST;
      ctcMatch_q <= `CSTW_CTCMATCH_RST;
      freqSel_q <= 2'b00;
      dblSel_q <= 2'b00;
      pllSel_q <= 2'b00;
      inDiv_q <= 6'h00;
      fbDiv_q <= 6'h00;
    end else begin
      clrReq_q <= 1'b0;
      if (wrPend_q) begin
        if (wrAddr_q == `CSTW_OFF_CTRL) begin
          ctrl_q <= hwdata[6:1];
          clrReq_q <= hwdata[`CSTW_CTRL_CLR_BIT];
        end else if (wrAddr_q == `CSTW_OFF_FASTTC) begin
          fastTc_q <= hwdata[4:0];
        end else if (wrAddr_q == `CSTW_OFF_CTCMATCH) begin
          ctcMatch_q <= hwdata[12:0];
        end else if (wrAddr_q == `CSTW_OFF_SRCSEL) begin
          freqSel_q <= hwdata[1:0];
          dblSel_q <= hwdata[`CSTW_SRC_DBL_LSB +: 2];
          pllSel_q <= hwdata[`CSTW_SRC_PLL_LSB +: 2];
        end else if (wrAddr_q == `CSTW_OFF_PLLDIV) begin
          inDiv_q <= hwdata[5:0];
          fbDiv_q <= hwdata[`CSTW_PLL_FB_LSB +: 6];
        end
      end
    end
  end

  // Divider setups; the CPU divider keeps only four divisor bits.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < `CSTW_NUM_DIV; k++) begin
        divCfg_q[k] <= '{src: 3'h0, divisor: `CSTW_DIVISOR_RST};
      end
    end else if (wrPend_q && divIdx(wrAddr_q) != 4'hF) begin
      divCfg_q[divIdx(wrAddr_q)].src <= hwdata[`CSTW_DIVREG_SRC_LSB +: 3];
      if (divIdx(wrAddr_q) == 4'(`CSTW_DIV_CPU)) begin
        divCfg_q[divIdx(wrAddr_q)].divisor <= {12'h000, hwdata[3:0]};
      end else begin
        divCfg_q[divIdx(wrAddr_q)].divisor <= hwdata[15:0];
      end
    end
  end

  // Settings to the analog parts. Fabric is code 2'b10; code 2'b11 also picks fabric.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mainFreq <= MAIN_3M;
      mainTrim <= 8'h00;
      doublerSrc <= REF_MAIN;
      pllSrc <= REF_MAIN;
      pllInDiv <= 6'h00;
      pllFbDiv <= 6'h00;
      pllEnable <= 1'b0;
      watchPwr <= 1'b0;
      usbLock <= 1'b0;
    end else begin
      mainFreq <= cstw_main_e'(freqSel_q);
      mainTrim <= TRIM_TABLE[{freqSel_q, 3'b000} +: 8];
      doublerSrc <= dblSel_q[1] ? REF_FABRIC : cstw_ref_e'(dblSel_q);
      pllSrc <= pllSel_q[1] ? REF_FABRIC : cstw_ref_e'(pllSel_q);
      pllInDiv <= inDiv_q;
      pllFbDiv <= fbDiv_q;
      pllEnable <= ctrl_q.pllEn;
      watchPwr <= ctrl_q.watchPwr;
      usbLock <= ctrl_q.usbLock;
    end
  end

  // ------------------------------------------------------------
  // Low-speed clocks and tick counters
  // ------------------------------------------------------------
  logic prev1k_q; // Last 1 kHz level.
  logic prev100k_q; // Last 100 kHz level.
  logic prevWatch_q; // Last watch crystal level.
  logic rise1k; // 1 kHz rising edge.
  logic rise100k; // 100 kHz rising edge.
  logic [15:0] watchCnt_q; // Watch crystal edges this second.

  assign rise1k = lowSpeed1k & ~prev1k_q;
  assign rise100k = lowSpeed100k & ~prev100k_q;

  // Direct low-speed clocks and edge history.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev1k_q <= 1'b0;
      prev100k_q <= 1'b0;
      prevWatch_q <= 1'b0;
      slowTickClk <= 1'b0;
      fastLowClk <= 1'b0;
    end else begin
      prev1k_q <= lowSpeed1k;
      prev100k_q <= lowSpeed100k;
      prevWatch_q <= watchXtalClk;
      slowTickClk <= lowSpeed1k;
      fastLowClk <= lowSpeed100k;
    end
  end

  // Central counter. A clear wins over a step; the hold stops stepping but not a clear.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctc_q <= 13'h0000;
      ctcIrq <= 1'b0;
      ctcWake <= 1'b0;
    end else begin
      ctcIrq <= 1'b0;
      ctcWake <= 1'b0;
      if (clrReq_q) begin
        ctc_q <= 13'h0000;
      end else if (rise1k && !hibernate && !debugHalt) begin
        ctc_q <= ctc_q + 13'h0001;
        if (ctc_q + 13'h0001 == ctcMatch_q) begin
          ctcIrq <= ctrl_q.ctcIrqEn;
          ctcWake <= ctrl_q.ctcWakeEn & lowPower;
        end
      end
    end
  end

  // Fast counter restarts on its own at the terminal count.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_q <= 5'h00;
      fastIrq <= 1'b0;
    end else begin
      fastIrq <= 1'b0;
      if (rise100k) begin
        if (fast_q == fastTc_q) begin
          fast_q <= 5'h00;
          fastIrq <= ctrl_q.fastIrqEn;
        end else begin
          fast_q <= fast_q + 5'h01;
        end
      end
    end
  end

  // One pulse per WATCH_EDGES watch crystal edges, i.e. each second.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      watchCnt_q <= 16'h0000;
      rtcSecIrq <= 1'b0;
    end else begin
      rtcSecIrq <= 1'b0;
      if (watchXtalClk && !prevWatch_q) begin
        if (watchCnt_q == 16'(WATCH_EDGES - 1)) begin
          watchCnt_q <= 16'h0000;
          rtcSecIrq <= 1'b1;
        end else begin
          watchCnt_q <= watchCnt_q + 16'h0001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // PLL lock tracking
  // ------------------------------------------------------------
  logic [31:0] lkCnt_q; // Cycles of the current lock wait.

  // Any change of reference or ratio restarts the wait, since the loop relocks.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lk_q <= LK_OFF;
      lkCnt_q <= 32'h0000_0000;
      pllLock <= 1'b0;
      pllLockFabric <= 1'b0;
    end else begin
      case (lk_q)
        LK_OFF: begin
          lkCnt_q <= 32'h0000_0000;
          if (ctrl_q.pllEn) begin
            lk_q <= LK_WAIT;
          end
        end
        LK_WAIT: begin
          lkCnt_q <= lkCnt_q + 32'h0000_0001;
          if (lkCnt_q == 32'(LOCK_CYC - 1)) begin
            lk_q <= LK_DONE;
          end
        end
        default: begin
          lkCnt_q <= 32'h0000_0000;
        end
      endcase
      if (!ctrl_q.pllEn) begin
        lk_q <= LK_OFF;
      end else if (wrPend_q && (wrAddr_q == `CSTW_OFF_PLLDIV || wrAddr_q == `CSTW_OFF_SRCSEL)) begin
        lk_q <= LK_WAIT;
        lkCnt_q <= 32'h0000_0000;
      end
      pllLock <= (lk_q == LK_DONE) && ctrl_q.pllEn;
      pllLockFabric <= (lk_q == LK_DONE) && ctrl_q.pllEn;
    end
  end

  // ------------------------------------------------------------
  // Dividers
  // ------------------------------------------------------------
  logic [7:0] srcLvl; // Divider inputs; the PLL is held off until locked.

  assign srcLvl = {dividedLowClk, lowSpeed100k, lowSpeed1k, doublerClk,
                   pllClk & pllLock, fabricClk, fastXtalClk, mainOscClk};

  // 33 kHz from 100 kHz by three.
  cstw_clkdiv u_div33 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .srcLvl({7'h00, lowSpeed100k}),
    .setup(cstw_div_s'{src: 3'h0, divisor: `CSTW_LOW_DIV}),
    .clkOut(dividedLowClk)
  );

  // Digital 0..7, analog 8..11, bus 12, CPU 13.
  for (genvar g = 0; g < `CSTW_NUM_DIV; g++) begin : g_div
    cstw_clkdiv u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .srcLvl(srcLvl),
      .setup(divCfg_q[g]),
      .clkOut(divClk[g])
    );
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence stepSeen;
    rise1k && !hibernate && !debugHalt && !clrReq_q;
  endsequence

  ctc_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stepSeen and (ctc_q == 13'h1FFF) |=> ctc_q == 13'h0000) else $error("central counter did not wrap");
  ctc_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stepSeen |=> ctc_q == $past(ctc_q) + 13'h0001) else $error("central counter missed a step");
  ctc_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (hibernate || debugHalt) && !clrReq_q |=> $stable(ctc_q)) else $error("central counter ran while held");
  ctc_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrPend_q && wrAddr_q == `CSTW_OFF_CTRL && hwdata[0] |=> ##1 ctc_q == 13'h0000)
    else $error("central counter not cleared");
  fast_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise100k && fast_q == fastTc_q |=> fast_q == 5'h00 && fastIrq == $past(ctrl_q.fastIrqEn))
    else $error("fast counter did not restart");
  fast_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fastIrq |-> $past(rise100k && fast_q == fastTc_q && ctrl_q.fastIrqEn)) else $error("stray fast interrupt");
  lock_early_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(ctrl_q.pllEn) |=> !pllLock [*8]) else $error("lock reported too early");
  lock_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl_q.pllEn |=> !pllLock && !pllLockFabric) else $error("lock kept with PLL off");
  bus_okay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 hreadyout && !hresp) else $error("slave stalled or erred");

endmodule : cstw_clock_sys

// File: verification/cstw_tb_top.sv
// Purpose: Self-checking bench for the clock system registers, tick counters and lock.
// Assumes: Zero wait state slave; lock and watch counts shortened by parameters.
// Notes: Low-speed levels are slow square waves made by the tick task.
module clock_system_and_timewheels_tb_top import cstw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } cstw_row_s; // One row: offset, written word, expected read.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hibernate = 1'b0, debugHalt = 1'b0, lowPower = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, sc = 3'h0, lsv = 3'h0; // Fast sources and low-speed levels.
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, slowTickClk, dividedLowClk, ctcIrq, ctcWake, fastIrq, rtcSecIrq;
  logic pllLock, pllLockFabric, divPrev, slowPrev;
  cstw_ref_e pllSrc;
  cstw_main_e mainFreq;
  cstw_ref_e doublerSrc;
  logic fastLowClk, pllEnable, watchPwr, usbLock, fastPrev;
  logic [5:0] pllInDiv, pllFbDiv;
  logic [7:0] mainTrim;
  logic [13:0] divClk;
  int numErrors = 0, numChecks = 0, cyc = 0, s0, s1, s2;
  int nFast = 0, nCtc = 0, nWake = 0, nRtc = 0, nDiv = 0, nSlow = 0, nHi = 0, nFl = 0;
  cstw_row_s rows [9] = '{'{8'h04, 32'h23, 32'h03}, '{8'h08, 32'hFFFFFFFF, 32'h1FFF},
    '{8'h14, 32'hFFFFFFFF, 32'h3F3F}, '{8'h40, 32'hFFFFFFFF, 32'h7FFFF},
    '{8'h70, 32'hFFFFFFFF, 32'h7FFFF}, '{8'h74, 32'hFFFFFFFF, 32'h7000F},
    '{8'h3C, 32'hFFFFFFFF, 32'h0}, '{8'h0C, 32'hFFFFFFFF, 32'h0}, '{8'h10, 32'h213, 32'h213}};

  // Distinct trim bytes so a wrong byte pick shows up.
  cstw_clock_sys #(.LOCK_CYC(20), .WATCH_EDGES(8), .TRIM_TABLE(32'h44332211)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mainOscClk(sc[0]), .fastXtalClk(sc[1]), .fabricClk(sc[2]),
    .pllClk(sc[0]), .doublerClk(sc[1]), .lowSpeed1k(lsv[0]), .lowSpeed100k(lsv[1]),
    .watchXtalClk(lsv[2]), .hibernate(hibernate), .debugHalt(debugHalt),
    .lowPower(lowPower), .slowTickClk(slowTickClk), .fastLowClk(fastLowClk),
    .dividedLowClk(dividedLowClk), .divClk(divClk), .ctcIrq(ctcIrq), .ctcWake(ctcWake),
    .fastIrq(fastIrq), .rtcSecIrq(rtcSecIrq), .pllLock(pllLock),
    .pllLockFabric(pllLockFabric), .pllEnable(pllEnable), .pllInDiv(pllInDiv), .pllFbDiv(pllFbDiv),
    .pllSrc(pllSrc), .doublerSrc(doublerSrc), .mainFreq(mainFreq), .mainTrim(mainTrim),
    .watchPwr(watchPwr), .usbLock(usbLock));

  // Clock at 100 MHz.
  always #5 ref_clk = ~ref_clk;

  // Counts pulses, rising edges and high cycles so tests compare differences, not raw levels.
  always @(posedge ref_clk) begin
    sc <= sc + 3'h1;
    cyc <= cyc + 1;
    divPrev <= dividedLowClk;
    slowPrev <= slowTickClk;
    fastPrev <= fastLowClk;
    if (divClk[1] === 1'b1) nHi <= nHi + 1;
    if (fastLowClk === 1'b1 && fastPrev === 1'b0) nFl <= nFl + 1;
    if (fastIrq === 1'b1) nFast <= nFast + 1;
    if (ctcIrq === 1'b1) nCtc <= nCtc + 1;
    if (ctcWake === 1'b1) nWake <= nWake + 1;
    if (rtcSecIrq === 1'b1) nRtc <= nRtc + 1;
    if (dividedLowClk === 1'b1 && divPrev === 1'b0) nDiv <= nDiv + 1;
    if (slowTickClk === 1'b1 && slowPrev === 1'b0) nSlow <= nSlow + 1;
  end

  // A hang is cut short well past the expected run of about 33000 cycles.
  always @(posedge ref_clk) begin
    if (cyc == 50000) begin
      numErrors = numErrors + 1;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One single word transfer; the read word lands in rd at the data phase edge.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Slow square wave on one level, two cycles high and two low, then a settle time.
  task automatic tick(input int b, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      lsv[b] <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      lsv[b] <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask : tick

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
    rst_n <= 1'b1;
    ahb(0, 8'h04, 0);
    chk("fast end reset", rd, 32'h1F);
    foreach (rows[i]) begin
      ahb(1, rows[i].a, rows[i].d);
      ahb(0, rows[i].a, 0);
      chk("readback", rd, rows[i].e);
    end
    repeat (2) @(posedge ref_clk);
    chk("mainFreq", 32'(mainFreq), 32'h3);
    chk("pllSrc", 32'(pllSrc), 32'h2);
    chk("doublerSrc", 32'(doublerSrc), 32'h1);
    chk("mainTrim", {24'h0, mainTrim}, 32'h44);
    chk("pllInDiv", {26'h0, pllInDiv}, 32'h3F);
    chk("pllFbDiv", {26'h0, pllFbDiv}, 32'h3F);
    // Divider 1 keeps its reset setup: divide by two of a source that rises every second cycle.
    s0 = nHi;
    repeat (40) @(posedge ref_clk);
    chk("duty", nHi - s0, 20);
    ahb(1, 8'h04, 32'h2);
    ahb(1, 8'h08, 32'h5);
    // Fast counter with end count 2 gives one event per three edges.
    ahb(1, 8'h00, 32'h2);
    s0 = nFast;
    s1 = nDiv;
    s2 = nFl;
    tick(1, 9);
    chk("fast events", nFast - s0, 3);
    chk("third edges", nDiv - s1, 3);
    chk("fast clock edges", nFl - s2, 9);
    ahb(0, 8'h0C, 0);
    chk("fast count", {27'h0, rd[20:16]}, 0);
    ahb(1, 8'h00, 32'h0);
    s0 = nFast;
    tick(1, 4);
    chk("fast masked", nFast - s0, 0);
    // Central counter: clear, halts, match, then a full wrap.
    tick(0, 2);
    lowPower <= 1'b1;
    ahb(1, 8'h00, 32'hD);
    s0 = nCtc;
    s1 = nWake;
    s2 = nSlow;
    ahb(0, 8'h0C, 0);
    chk("cleared", {19'h0, rd[12:0]}, 0);
    tick(0, 3);
    hibernate <= 1'b1;
    tick(0, 2);
    hibernate <= 1'b0;
    debugHalt <= 1'b1;
    tick(0, 1);
    debugHalt <= 1'b0;
    ahb(0, 8'h0C, 0);
    chk("halted", {19'h0, rd[12:0]}, 3);
    tick(0, 2);
    ahb(0, 8'h0C, 0);
    chk("count", {19'h0, rd[12:0]}, 5);
    chk("match event", nCtc - s0, 1);
    chk("wake event", nWake - s1, 1);
    chk("slow edges", nSlow - s2, 8);
    lowPower <= 1'b0;
    tick(0, 8192);
    ahb(0, 8'h0C, 0);
    chk("wrapped", {19'h0, rd[12:0]}, 5);
    chk("match again", nCtc - s0, 2);
    chk("wake gated", nWake - s1, 1);
    // Lock comes only after the wait count and drops when disabled.
    ahb(1, 8'h00, 32'h70);
    chk("early lock", {31'h0, pllLock}, 0);
    for (int k = 0; k < 60 && pllLock !== 1'b1; k++) @(posedge ref_clk);
    chk("lock", {31'h0, pllLock}, 1);
    chk("lock out", {31'h0, pllLockFabric}, 1);
    chk("pllEnable", {31'h0, pllEnable}, 1);
    chk("watchPwr", {31'h0, watchPwr}, 1);
    chk("usbLock", {31'h0, usbLock}, 1);
    ahb(0, 8'h0C, 0);
    chk("lock bit", {31'h0, rd[24]}, 1);
    // A new ratio restarts the lock wait.
    ahb(1, 8'h14, 32'h0101);
    repeat (2) @(posedge ref_clk);
    chk("relock", {31'h0, pllLock}, 0);
    ahb(1, 8'h00, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("unlock", {31'h0, pllLock}, 0);
    chk("pll off", {31'h0, pllEnable}, 0);
    s0 = nRtc;
    tick(2, 8);
    chk("second event", nRtc - s0, 1);
    summarize();
  end
endmodule : clock_system_and_timewheels_tb_top
